// ==== src/sslink_top.sv ====
`include "sslink_regs.svh"

module sslink_top
    import sslink_pkg::*;
#(
    parameter int unsigned BIT_CYC_LO = `SSL_CLK_HZ / `SSL_RATE_LO_BPS,
    parameter int unsigned BIT_CYC_HI = `SSL_CLK_HZ / `SSL_RATE_HI_BPS,
    parameter int unsigned HOLD_CYC   = `SSL_HOLD_MS * (`SSL_CLK_HZ / `SSL_MS_PER_S),
    parameter int unsigned FIFO_DEPTH = `SSL_FIFO_DEPTH
)
(
    // Clock, reset, enable
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    // Encoder pins
    input  wire logic [`SSL_NUM_LINES-1:0] enc_switch_lines_i,
    input  wire logic                      enc_rate_sel_i,
    output logic                           enc_ser_o,
    output logic                           enc_awake_o,
    // Decoder pins
    input  wire logic                      dec_ser_i,
    input  wire logic                      dec_rate_sel_i,
    output logic      [`SSL_NUM_LINES-1:0] dec_switch_lines_o
);

    localparam int unsigned TW = `SSL_TMR_W;
    localparam int unsigned HW = `SSL_HOLD_W;
    localparam int unsigned BW = `SSL_BYTE_W;

    function automatic logic [TW-1:0] bit_cyc(input logic rate_hi);
        return rate_hi ? TW'(BIT_CYC_HI) : TW'(BIT_CYC_LO);
    endfunction

    // Reset release
    logic [1:0] rst_sync_ff;
    wire        rst_n = rst_sync_ff[1];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_ff <= 2'h0;
        else if (ce_i)
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    // Pin filtering
    logic [`SSL_NUM_LINES-1:0] sw_s;
    logic                      enc_rate_s;
    logic                      dec_rate_s;
    logic                      rx_s;

    sslink_sync #(
        .WIDTH (`SSL_NUM_LINES + 3)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .async_i ({dec_ser_i, dec_rate_sel_i, enc_rate_sel_i, enc_switch_lines_i}),
        .sync_o  ({rx_s, dec_rate_s, enc_rate_s, sw_s})
    );

    // ---- Encoder: packet builder ----
    sslink_enc_state_type      enc_ff;
    sslink_enc_state_type      nxt_enc;
    logic [`SSL_NUM_LINES-1:0] cap_ff;
    logic                      awake_ff;

    logic                      fifo_wr_ready;
    logic                      fifo_rd_valid;
    logic [BW-1:0]             fifo_rd_data;
    logic                      tx_busy_ff;

    wire any_high   = |sw_s;
    wire line_quiet = !fifo_rd_valid && !tx_busy_ff;
    wire can_start  = (enc_ff == ENC_SLEEP) || ((enc_ff == ENC_WAIT) && line_quiet);
    wire start_pkt  = can_start && any_high;
    wire fifo_wr    = (enc_ff == ENC_HEAD) || (enc_ff == ENC_COPY);
    wire [BW-1:0] fifo_wr_data = sslink_code(cap_ff);

    always_comb
    begin
        nxt_enc = enc_ff;
        case (enc_ff)
            ENC_SLEEP:
                if (start_pkt)
                    nxt_enc = ENC_HEAD;
            ENC_HEAD:
                if (fifo_wr_ready)
                    nxt_enc = ENC_COPY;
            ENC_COPY:
                if (fifo_wr_ready)
                    nxt_enc = ENC_WAIT;
            ENC_WAIT:
                if (line_quiet)
                    nxt_enc = any_high ? ENC_HEAD : ENC_SLEEP;
            default:
                nxt_enc = ENC_SLEEP;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enc_ff   <= ENC_SLEEP;
            cap_ff   <= '0;
            awake_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            enc_ff   <= nxt_enc;
            awake_ff <= (nxt_enc != ENC_SLEEP);
            if (start_pkt)
                cap_ff <= sw_s;
        end
    end

    // One packet's worth of slack would do; the encoder waits for the line to drain before the next packet
    sslink_fifo #(
        .WIDTH (BW),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .ce_i       (ce_i),
        .wr_valid_i (fifo_wr),
        .wr_ready_o (fifo_wr_ready),
        .wr_data_i  (fifo_wr_data),
        .rd_valid_o (fifo_rd_valid),
        .rd_ready_i (!tx_busy_ff),
        .rd_data_o  (fifo_rd_data)
    );

    // ---- Encoder: serialiser ----
    logic [BW:0]   tx_shift_ff;
    logic [3:0]    tx_left_ff;
    logic [TW-1:0] tx_tmr_ff;
    logic          tx_rate_ff;
    logic          ser_ff;

    wire tx_load = !tx_busy_ff && fifo_rd_valid;
    wire tx_tick = tx_busy_ff && (tx_tmr_ff == '0);
    wire tx_last = (tx_left_ff == 4'h0);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_busy_ff  <= 1'b0;
            tx_shift_ff <= '0;
            tx_left_ff  <= 4'h0;
            tx_tmr_ff   <= '0;
            tx_rate_ff  <= 1'b0;
            ser_ff      <= `SSL_IDLE_LVL;
        end
        else if (ce_i)
        begin
            if (tx_load)
            begin
                tx_busy_ff  <= 1'b1;
                tx_rate_ff  <= enc_rate_s;
                tx_tmr_ff   <= bit_cyc(enc_rate_s) - 1'b1;
                tx_shift_ff <= {`SSL_STOP_LVL, fifo_rd_data};
                tx_left_ff  <= 4'(BW + 1);
                ser_ff      <= `SSL_START_LVL;
            end
            else if (tx_tick)
            begin
                tx_tmr_ff <= bit_cyc(tx_rate_ff) - 1'b1;
                if (tx_last)
                begin
                    tx_busy_ff <= 1'b0;
                    ser_ff     <= `SSL_IDLE_LVL;
                end
                else
                begin
                    ser_ff      <= tx_shift_ff[0];
                    tx_shift_ff <= {1'b0, tx_shift_ff[BW:1]};
                    tx_left_ff  <= tx_left_ff - 1'b1;
                end
            end
            else if (tx_busy_ff)
                tx_tmr_ff <= tx_tmr_ff - 1'b1;
        end
    end

    // ---- Decoder: byte receiver ----
    sslink_dec_state_type      dec_ff;
    logic                      rx_prev_ff;
    logic [TW-1:0]             rx_tmr_ff;
    logic [2:0]                rx_cnt_ff;
    logic [BW-1:0]             rx_shift_ff;
    logic                      rx_rate_ff;
    logic                      head_ok_ff;
    logic [BW-1:0]             head_byte_ff;
    logic [`SSL_NUM_LINES-1:0] out_ff;
    logic [HW-1:0]             hold_ff;

    wire rx_rise  = rx_s && !rx_prev_ff;
    wire rx_tick  = (rx_tmr_ff == '0);
    wire byte_end = (dec_ff == DEC_STOP) && rx_tick;
    wire frame_ok = (rx_s == `SSL_STOP_LVL);
    wire code_ok  = sslink_code_ok(rx_shift_ff);
    wire pkt_ok   = byte_end && frame_ok && head_ok_ff && (rx_shift_ff == head_byte_ff);
    wire hold_end = (hold_ff == HW'(1));

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dec_ff      <= DEC_IDLE;
            rx_prev_ff  <= 1'b0;
            rx_tmr_ff   <= '0;
            rx_cnt_ff   <= 3'h0;
            rx_shift_ff <= '0;
            rx_rate_ff  <= 1'b0;
        end
        else if (ce_i)
        begin
            rx_prev_ff <= rx_s;
            case (dec_ff)
                DEC_IDLE:
                    if (rx_rise)
                    begin
                        rx_rate_ff <= dec_rate_s;
                        rx_tmr_ff  <= (bit_cyc(dec_rate_s) >> 1) - 1'b1;
                        dec_ff     <= DEC_START;
                    end
                DEC_START:
                    if (rx_tick)
                    begin
                        rx_tmr_ff <= bit_cyc(rx_rate_ff) - 1'b1;
                        rx_cnt_ff <= 3'h0;
                        // A glitch that is gone by mid start bit is not a byte
                        dec_ff    <= (rx_s == `SSL_START_LVL) ? DEC_DATA : DEC_IDLE;
                    end
                    else
                        rx_tmr_ff <= rx_tmr_ff - 1'b1;
                DEC_DATA:
                    if (rx_tick)
                    begin
                        rx_tmr_ff   <= bit_cyc(rx_rate_ff) - 1'b1;
                        rx_shift_ff <= {rx_s, rx_shift_ff[BW-1:1]};
                        rx_cnt_ff   <= rx_cnt_ff + 1'b1;
                        if (rx_cnt_ff == 3'h7)
                            dec_ff <= DEC_STOP;
                    end
                    else
                        rx_tmr_ff <= rx_tmr_ff - 1'b1;
                DEC_STOP:
                    if (rx_tick)
                        dec_ff <= DEC_IDLE;
                    else
                        rx_tmr_ff <= rx_tmr_ff - 1'b1;
                default:
                    dec_ff <= DEC_IDLE;
            endcase
        end
    end

    // Byte pairing; a lost byte only shifts the pairing, copies are identical
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_ok_ff   <= 1'b0;
            head_byte_ff <= '0;
        end
        else if (ce_i)
        begin
            if (byte_end)
            begin
                head_ok_ff   <= frame_ok && code_ok && !pkt_ok;
                head_byte_ff <= rx_shift_ff;
            end
            else if (hold_end)
                head_ok_ff <= 1'b0;
        end
    end

    // Output hold timer
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ff  <= '0;
            hold_ff <= '0;
        end
        else if (ce_i)
        begin
            if (pkt_ok)
            begin
                out_ff  <= rx_shift_ff[`SSL_NUM_LINES-1:0];
                hold_ff <= HW'(HOLD_CYC);
            end
            else if (hold_end)
            begin
                out_ff  <= '0;
                hold_ff <= '0;
            end
            else if (hold_ff != '0)
                hold_ff <= hold_ff - 1'b1;
        end
    end

    assign enc_ser_o          = ser_ff;
    assign enc_awake_o        = awake_ff;
    assign dec_switch_lines_o = out_ff;

endmodule

// ==== src/sslink_regs.svh ====
`ifndef SSLINK_REGS_SVH
`define SSLINK_REGS_SVH

// Summary of operation
// - Encoder and decoder both run the serial line at 2,400 bps with rate select low and 9,600 bps with it high.
// - After reset the encoder sleeps and sends nothing until it is woken.
// - The encoder wakes and starts a transmit sequence as soon as any switch line is sampled high.
// - Per packet the encoder captures the switch lines, adds check coding, builds the packet and shifts it out.
// - The encoder repeats packets while any switch line is high and sleeps once all are low.
// - The switch lines are resampled before each packet so every packet carries levels current at its start.
// - A started packet is always sent to the end, even if every switch line drops during it.
// - The decoder idles until a low-to-high edge on its serial input and takes that edge as a byte start.
// - The decoder checks framing and coding of a packet and drives its four outputs only if all checks pass.
// - A packet that fails any check is dropped, outputs stay unchanged, and the decoder watches for the next.
// - Decoder outputs hold until a valid packet changes them or 131 ms pass, and each valid packet restarts that time.
// - When 131 ms expire with no valid packet, all four outputs go low and the decoder returns to idle.

`define SSL_CLK_HZ        125000000
`define SSL_RATE_LO_BPS   2400
`define SSL_RATE_HI_BPS   9600
`define SSL_HOLD_MS       131
`define SSL_MS_PER_S      1000
`define SSL_NUM_LINES     4
`define SSL_BYTE_W        8
`define SSL_PKT_BYTES     2
`define SSL_FIFO_DEPTH    16
`define SSL_START_LVL     1'b1
`define SSL_STOP_LVL      1'b0
`define SSL_IDLE_LVL      1'b0
`define SSL_TMR_W         16
`define SSL_HOLD_W        24

`endif

// ==== src/sslink_pkg.sv ====
`include "sslink_regs.svh"

package sslink_pkg;

    typedef enum logic [1:0]
    {
        ENC_SLEEP,
        ENC_HEAD,
        ENC_COPY,
        ENC_WAIT
    } sslink_enc_state_type;

    typedef enum logic [1:0]
    {
        DEC_IDLE,
        DEC_START,
        DEC_DATA,
        DEC_STOP
    } sslink_dec_state_type;

    // Upper nibble carries the complement of the switch bits
    function automatic logic [`SSL_BYTE_W-1:0] sslink_code(input logic [`SSL_NUM_LINES-1:0] sw);
        return {~sw, sw};
    endfunction

    function automatic logic sslink_code_ok(input logic [`SSL_BYTE_W-1:0] b);
        return (b[7:4] == ~b[3:0]);
    endfunction

endpackage

// ==== src/sslink_sync.sv ====
`include "sslink_regs.svh"

module sslink_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // Asynchronous levels in, filtered levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] out_ff;

    wire  [WIDTH-1:0] agree    = ~(stage2_ff ^ stage3_ff);
    wire  [WIDTH-1:0] nxt_out  = (stage3_ff & agree) | (out_ff & ~agree);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            out_ff    <= '0;
        end
        else if (ce_i)
        begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            out_ff    <= nxt_out;
        end
    end

    assign sync_o = out_ff;

endmodule

// ==== src/sslink_fifo.sv ====
module sslink_fifo
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // Drain side
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic      [WIDTH-1:0] rd_data_o
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;

    wire full  = (count_ff == (AW+1)'(DEPTH));
    wire empty = (count_ff == '0);
    wire push  = wr_valid_i && !full && ce_i;
    wire pop   = rd_ready_i && !empty && ce_i;

    wire [AW-1:0] nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
    wire [AW-1:0] nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr_ff] <= wr_data_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= nxt_wr_ptr;
            if (pop)
                rd_ptr_ff <= nxt_rd_ptr;
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end

    assign wr_ready_o = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o  = mem[rd_ptr_ff];

endmodule

// ==== tb/sslink_top_asserts.sv ====
`include "sslink_regs.svh"

module sslink_top_asserts
    import sslink_pkg::*;
#(
    parameter int unsigned BIT_CYC_LO = 40,
    parameter int unsigned BIT_CYC_HI = 16,
    parameter int unsigned HOLD_CYC   = 2000,
    parameter int unsigned FIFO_DEPTH = 16
)
(
    // Clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    input wire logic                      ce_i,
    // Encoder pins
    input wire logic [`SSL_NUM_LINES-1:0] enc_switch_lines_i,
    input wire logic                      enc_rate_sel_i,
    input wire logic                      enc_ser_o,
    input wire logic                      enc_awake_o,
    // Decoder pins
    input wire logic                      dec_ser_i,
    input wire logic                      dec_rate_sel_i,
    input wire logic [`SSL_NUM_LINES-1:0] dec_switch_lines_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Hold restarts up to a bit after the line goes quiet, so allow that slack
    localparam int QUIET_LIM = int'(HOLD_CYC + BIT_CYC_LO) + 16;
    localparam int SLEEP_LIM = 20 * int'(BIT_CYC_LO) + 32;

    int hi_run;
    int lo_run;
    int quiet;
    int idle_sw;
    int bce;
    int bcd;

    assign bce = enc_rate_sel_i ? int'(BIT_CYC_HI) : int'(BIT_CYC_LO);
    assign bcd = dec_rate_sel_i ? int'(BIT_CYC_HI) : int'(BIT_CYC_LO);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hi_run  <= 0;
            lo_run  <= 0;
            quiet   <= 0;
            idle_sw <= 0;
        end
        else
        begin
            hi_run  <= enc_ser_o ? hi_run + 1 : 0;
            lo_run  <= enc_ser_o ? 0 : lo_run + 1;
            quiet   <= dec_ser_i ? 0 : quiet + 1;
            idle_sw <= (enc_awake_o && enc_switch_lines_i == '0) ? idle_sw + 1 : 0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    // A frozen block keeps no time, so nothing is judged while it is held
    default disable iff (!rst_n_i || !ce_i);

    a_sleep_line_low: assert property (!enc_awake_o |-> !enc_ser_o)
        else $error("serial line high while asleep");
    a_wake_on_switch: assert property ((enc_switch_lines_i != '0)[*8] |-> enc_awake_o)
        else $error("encoder not awake with a switch high");
    a_start_after_wake: assert property ($rose(enc_awake_o) |-> ##[1:8] enc_ser_o)
        else $error("no start bit after wake");
    a_high_run_bits: assert property ($fell(enc_ser_o) |-> hi_run % bce == 0 && hi_run <= 5 * bce)
        else $error("high run not whole bits");
    a_low_run_bits: assert property ($rose(enc_ser_o) |-> lo_run >= bce)
        else $error("low run shorter than a bit");
    a_sleep_bound: assert property (enc_awake_o |-> idle_sw <= SLEEP_LIM)
        else $error("encoder awake too long with switches low");
    a_update_at_stop: assert property ($changed(dec_switch_lines_o) && dec_switch_lines_o != '0 |-> quiet > 0 && quiet <= bcd)
        else $error("decoder output changed outside a stop bit");
    a_hold_clear: assert property (quiet >= QUIET_LIM |-> dec_switch_lines_o == '0)
        else $error("decoder outputs not cleared after hold");

    c_wake: cover property ($rose(enc_awake_o));
    c_decoded: cover property ($changed(dec_switch_lines_o) && dec_switch_lines_o != '0);
    c_cleared: cover property ($changed(dec_switch_lines_o) && dec_switch_lines_o == '0);
endmodule

// ==== tb/sslink_far_end.sv ====
module sslink_far_end
#(
    parameter int unsigned BIT_CYC_LO = 40,
    parameter int unsigned BIT_CYC_HI = 16
)
(
    // Clock and rate strap
    input  wire logic clk_i,
    input  wire logic rate_sel_i,
    // Line from the encoder, line to the decoder
    input  wire logic line_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx_q[$];

    initial line_o = 1'b0;

    // A bad stop is queued as 00, which no valid code byte can be
    task automatic rx_byte();
        logic [7:0] b;
        int unsigned n;
        @(posedge line_i);
        n = rate_sel_i ? BIT_CYC_HI : BIT_CYC_LO;
        repeat (n / 2) @(posedge clk_i);
        if (line_i === 1'b1)
        begin
            for (int i = 0; i < 8; i++)
            begin
                repeat (n) @(posedge clk_i);
                b[i] = line_i;
            end
            repeat (n) @(posedge clk_i);
            rx_q.push_back(line_i === 1'b0 ? b : 8'h00);
        end
    endtask

    initial
    begin
        forever rx_byte();
    end

    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        int unsigned n;
        frame = {stop, b, 1'b1};
        n = rate_sel_i ? BIT_CYC_HI : BIT_CYC_LO;
        for (int i = 0; i < 10; i++)
        begin
            line_o <= frame[i];
            repeat (n) @(posedge clk_i);
        end
        // Idle low long enough to pass the input filter
        line_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// ==== tb/sslink_top_tb.sv ====
module sslink_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned BC_LO = 40;
    localparam int unsigned BC_HI = 16;
    // Long enough to outlast four slow pairs after the first valid one
    localparam int unsigned HOLD  = 4000;
    localparam int          LIMIT = 60000;

    logic       clk_i;
    logic       rst_n_i;
    logic       ce_i;
    logic [3:0] sw;
    logic       rate;
    logic       enc_ser_o;
    logic       enc_awake_o;
    logic       dec_ser_i;
    logic [3:0] dec_out;
    int         err_total = 0;
    int         checked = 0;
    int         cycles = 0;

    sslink_top #(.BIT_CYC_LO(BC_LO), .BIT_CYC_HI(BC_HI), .HOLD_CYC(HOLD), .FIFO_DEPTH(16)) i_sslink_top (
        .clk_i              (clk_i),
        .rst_n_i            (rst_n_i),
        .ce_i               (ce_i),
        .enc_switch_lines_i (sw),
        .enc_rate_sel_i     (rate),
        .enc_ser_o          (enc_ser_o),
        .enc_awake_o        (enc_awake_o),
        .dec_ser_i          (dec_ser_i),
        .dec_rate_sel_i     (rate),
        .dec_switch_lines_o (dec_out)
    );

    sslink_far_end #(.BIT_CYC_LO(BC_LO), .BIT_CYC_HI(BC_HI)) i_sslink_far_end (
        .clk_i      (clk_i),
        .rate_sel_i (rate),
        .line_i     (enc_ser_o),
        .line_o     (dec_ser_i)
    );

    always #4 clk_i = ~clk_i;

    task automatic summarize();
        $display("Checks %0d, errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] rxb(input int i);
        return i_sslink_far_end.rx_q[i];
    endfunction

    task automatic wait_bytes(input int n);
        for (int k = 0; k < 4000 && i_sslink_far_end.rx_q.size() < n; k++)
            @(posedge clk_i);
    endtask

    task automatic t_sleep();
        repeat (300) @(posedge clk_i);
        check("awake", {7'h00, enc_awake_o}, 8'h00);
        check("bytes", 8'(i_sslink_far_end.rx_q.size()), 8'h00);
        // A switch that comes and goes while the block is held must leave no trace
        ce_i <= 1'b0;
        sw   <= 4'h3;
        repeat (50) @(posedge clk_i);
        sw   <= 4'h0;
        ce_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        check("frozen", {7'h00, enc_awake_o}, 8'h00);
    endtask

    task automatic t_encode(input logic r, input logic [3:0] s1, input logic [3:0] s2);
        int n;
        rate <= r;
        repeat (16) @(posedge clk_i);
        i_sslink_far_end.rx_q.delete();
        sw <= s1;
        wait_bytes(2);
        check("first byte", rxb(0), {~s1, s1});
        check("copy byte", rxb(1), {~s1, s1});
        sw <= s2;
        wait_bytes(6);
        check("resampled", rxb(4), {~s2, s2});
        check("resampled copy", rxb(5), {~s2, s2});
        @(posedge enc_ser_o);
        sw <= 4'h0;
        for (int k = 0; k < 2000 && enc_awake_o; k++)
            @(posedge clk_i);
        repeat (40) @(posedge clk_i);
        n = i_sslink_far_end.rx_q.size();
        check("asleep", {7'h00, enc_awake_o}, 8'h00);
        check("whole pairs", 8'(n % 2), 8'h00);
        check("last byte", rxb(n - 1), {~s2, s2});
    endtask

    task automatic send_pair(input logic [7:0] a, input logic [7:0] b, input logic stop);
        i_sslink_far_end.send_byte(a, stop);
        i_sslink_far_end.send_byte(b, stop);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic t_decode(input logic r);
        rate <= r;
        repeat (16) @(posedge clk_i);
        send_pair(8'h96, 8'h96, 1'b0);
        check("valid pair", {4'h0, dec_out}, 8'h06);
        send_pair(8'h39, 8'h39, 1'b0);
        check("bad code", {4'h0, dec_out}, 8'h06);
        send_pair(8'hc3, 8'hc3, 1'b1);
        check("bad stop", {4'h0, dec_out}, 8'h06);
        send_pair(8'hc3, 8'ha5, 1'b0);
        check("split pair", {4'h0, dec_out}, 8'h06);
        send_pair(8'hc3, 8'hc3, 1'b0);
        check("new value", {4'h0, dec_out}, 8'h03);
        repeat (HOLD / 2) @(posedge clk_i);
        check("held", {4'h0, dec_out}, 8'h03);
        send_pair(8'hc3, 8'hc3, 1'b0);
        // Past the end of the earlier hold time, inside the restarted one
        repeat (HOLD / 2 + 300) @(posedge clk_i);
        check("refreshed", {4'h0, dec_out}, 8'h03);
        repeat (HOLD) @(posedge clk_i);
        check("hold expiry", {4'h0, dec_out}, 8'h00);
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        sw = 4'h0;
        rate = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_sleep();
        t_encode(1'b0, 4'h5, 4'ha);
        t_encode(1'b1, 4'hf, 4'h8);
        t_decode(1'b1);
        t_decode(1'b0);
        summarize();
    end
endmodule

bind sslink_top sslink_top_asserts #(
    .BIT_CYC_LO (BIT_CYC_LO),
    .BIT_CYC_HI (BIT_CYC_HI),
    .HOLD_CYC   (HOLD_CYC),
    .FIFO_DEPTH (FIFO_DEPTH)
) i_sslink_top_asserts (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .ce_i               (ce_i),
    .enc_switch_lines_i (enc_switch_lines_i),
    .enc_rate_sel_i     (enc_rate_sel_i),
    .enc_ser_o          (enc_ser_o),
    .enc_awake_o        (enc_awake_o),
    .dec_ser_i          (dec_ser_i),
    .dec_rate_sel_i     (dec_rate_sel_i),
    .dec_switch_lines_o (dec_switch_lines_o)
);
